// *** common/tpic_pkg.sv ***
// Constants, types and decoding shared by the timer pin I/O control block.
// Assumes a single clock domain and an AXI4-Lite register bus with 32-bit data.
// Operation
// RL1 - Codes 0000 and 0100 hold the pin; pin stays low until control is written.
// RL2 - Code 0001 starts low, 0101 starts high; both drive low on compare match.
// RL3 - Code 0010 starts low, 0110 starts high; both drive high on compare match.
// RL4 - Code 0011 starts low, 0111 starts high; both toggle on every compare match.
// RL5 - Bit 7 set, bits 5:4 at 00: capture the count on a rising pin edge.
// RL6 - Bit 7 set, bits 5:4 at 01: capture the count on a falling pin edge.
// RL7 - Bit 7 and bit 5 set: capture on both edges, bit 4 ignored.
// RL8 - Channel 1 code 11XX captures on channel-0 C events; elsewhere bit 6 ignored.
// RL9 - Channel-0 D in buffer mode: pin setting ignored, no match or capture; a code write still applies its initial level and enable.
// RL10 - Writing an output-compare code applies its initial level at once.
package tpic_pkg;

  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_CH = 4;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL_CH1 = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CTRL_CH2 = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CTRL_CH3 = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_CTRL_CH0_LOW = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_MODE_CH0 = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_CAPT_CH1 = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_CAPT_CH2 = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_CAPT_CH3 = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_CAPT_CH0_D = 8'h20;

  // Field layout
  localparam int CTRL_W = 8;
  localparam int CODE_LSB = 4;
  localparam int CODE_W = 4;
  localparam int BUF_MODE_BIT = 0;
  localparam int CB_CAPTURE = 3;
  localparam int CB_SOURCE = 2;
  localparam int CB_BOTH = 1;
  localparam int CB_FALL = 0;

  // Reset values and responses
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Function selected by a pin code
  typedef enum logic [2:0] {
    M_HOLD, M_OC_LOW, M_OC_HIGH, M_OC_TOGGLE, M_CAP_RISE, M_CAP_FALL, M_CAP_BOTH, M_CAP_CROSS
  } tpic_mode_t;

  // Pin drive pair
  typedef struct packed {
    logic out;
    logic oe;
  } tpic_pin_t;

  // Synchronised pin events
  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } tpic_edge_t;

  // Maps a four-bit pin code to its function
  function automatic tpic_mode_t tpic_decode(input logic [CODE_W-1:0] c, input logic cross_ok);
    tpic_mode_t m;
    m = M_HOLD;
    if (c[CB_CAPTURE]) begin
      if (cross_ok && c[CB_SOURCE]) begin
        m = M_CAP_CROSS; // RL8
      end else if (c[CB_BOTH]) begin
        m = M_CAP_BOTH; // RL7
      end else if (c[CB_FALL]) begin
        m = M_CAP_FALL; // RL6
      end else begin
        m = M_CAP_RISE; // RL5
      end
    end else begin
      case ({c[CB_BOTH], c[CB_FALL]})
        2'h0: m = M_HOLD; // RL1
        2'h1: m = M_OC_LOW; // RL2
        2'h2: m = M_OC_HIGH; // RL3
        default: m = M_OC_TOGGLE; // RL4
      endcase
    end
    return m;
  endfunction : tpic_decode

endpackage : tpic_pkg

// *** hdl/tpic_pin_sync.sv ***
// Three-stage synchroniser for a timer pin with edge detection.
// Assumes the pin is asynchronous to clock; edges come a few cycles late.
`timescale 1ns/1ps
module tpic_pin_sync
  import tpic_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Pin and events
  input wire logic pin_async,
  output tpic_edge_t edges
);

  logic [2:0] stage;
  logic [2:0] next_stage;
  tpic_edge_t next_edges;

  // Shift chain; a change counts once stages two and three agree
  always_comb begin
    next_stage = {stage[1:0], pin_async};
    next_edges = '{level: edges.level, rise: 1'b0, fall: 1'b0};
    if (stage[1] == stage[2] && stage[2] != edges.level) begin
      next_edges.level = stage[2];
      next_edges.rise = stage[2];
      next_edges.fall = ~stage[2];
    end
  end

  // Registers
  always_ff @(posedge clock) begin
    if (rst) begin
      stage <= 3'h0;
      edges <= '0;
    end else begin
      stage <= next_stage;
      edges <= next_edges;
    end
  end

endmodule : tpic_pin_sync

// *** hdl/tpic_channel.sv ***
// One pin channel: output compare drive or input capture decision.
// Assumes compare match and cross events are one-cycle pulses on clock.
`timescale 1ns/1ps
module tpic_channel
  import tpic_pkg::*;
#(
  parameter bit CROSS_OK = 1'b0
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Configuration
  input wire logic [CODE_W-1:0] code,
  input wire logic code_write,
  input wire logic disable_io,
  input wire logic standby,
  // Events
  input wire logic compare_match,
  input wire logic cross_event,
  input wire tpic_edge_t edges,
  // Results
  output tpic_pin_t pin,
  output logic capture_now
);

  tpic_mode_t mode;
  tpic_pin_t next_pin;
  logic written;
  logic next_written;

  assign mode = tpic_decode(code, CROSS_OK);

  // Capture request from the selected source
  always_comb begin
    capture_now = 1'b0;
    if (!disable_io && !standby) begin // RL9
      case (mode)
        M_CAP_RISE: capture_now = edges.rise; // RL5
        M_CAP_FALL: capture_now = edges.fall; // RL6
        M_CAP_BOTH: capture_now = edges.rise | edges.fall; // RL7
        M_CAP_CROSS: capture_now = cross_event; // RL8
        default: capture_now = 1'b0;
      endcase
    end
  end

  // Pin drive: low until written, initial level on write, action on match
  always_comb begin
    next_pin = pin;
    next_written = written;
    if (standby) begin
      next_written = 1'b0; // RL1
      next_pin = '{out: 1'b0, oe: 1'b1};
    end else if (code_write) begin
      next_written = 1'b1;
      next_pin.oe = ~code[CB_CAPTURE];
      if (!code[CB_CAPTURE] && mode != M_HOLD) begin
        next_pin.out = code[CB_SOURCE]; // RL10
      end
    end else if (written && !disable_io && compare_match) begin // RL9
      case (mode)
        M_OC_LOW: next_pin.out = 1'b0; // RL2
        M_OC_HIGH: next_pin.out = 1'b1; // RL3
        M_OC_TOGGLE: next_pin.out = ~pin.out; // RL4
        default: next_pin.out = pin.out; // RL1
      endcase
    end
  end

  // Registers
  always_ff @(posedge clock) begin
    if (rst) begin
      pin <= '{out: 1'b0, oe: 1'b1};
      written <= 1'b0;
    end else begin
      pin <= next_pin;
      written <= next_written;
    end
  end

endmodule : tpic_channel

// *** hdl/tpic_top.sv ***
// Timer pin I/O control: AXI4-Lite registers, four pin channels, capture store.
// Channel index 0 is channel-0 pin D, indices 1..3 are pin B of channels 1..3.
// Assumes count, compare matches and the C event come from logic on clock.
`timescale 1ns/1ps
module tpic_top
  import tpic_pkg::*;
#(
  parameter int COUNT_W = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // AXI4-Lite write address
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [ADDR_W-1:0] s_awaddr,
  input wire logic [2:0] s_awprot,
  // AXI4-Lite write data
  input wire logic s_wvalid,
  output logic s_wready,
  input wire logic [DATA_W-1:0] s_wdata,
  input wire logic [DATA_W/8-1:0] s_wstrb,
  // AXI4-Lite write response
  output logic s_bvalid,
  input wire logic s_bready,
  output logic [1:0] s_bresp,
  // AXI4-Lite read address
  input wire logic s_arvalid,
  output logic s_arready,
  input wire logic [ADDR_W-1:0] s_araddr,
  input wire logic [2:0] s_arprot,
  // AXI4-Lite read data
  output logic s_rvalid,
  input wire logic s_rready,
  output logic [DATA_W-1:0] s_rdata,
  output logic [1:0] s_rresp,
  // Timer datapath
  input wire logic [COUNT_W-1:0] count,
  input wire logic [NUM_CH-1:0] compare_match,
  input wire logic ch0_c_event,
  input wire logic standby,
  // Timer pins
  input wire logic [NUM_CH-1:0] pin_in,
  output logic [NUM_CH-1:0] pin_out,
  output logic [NUM_CH-1:0] pin_oe,
  // Capture strobes
  output logic [NUM_CH-1:0] capture_strobe
);

  // Write channel state
  logic aw_held;
  logic next_aw_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [ADDR_W-1:0] next_aw_addr;
  logic w_held;
  logic next_w_held;
  logic [DATA_W-1:0] w_data;
  logic [DATA_W-1:0] next_w_data;
  logic w_lane0;
  logic next_w_lane0;
  logic next_awready;
  logic next_wready;
  logic next_bvalid;
  logic [1:0] next_bresp;

  // Read channel state
  logic next_arready;
  logic next_rvalid;
  logic [1:0] next_rresp;
  logic [DATA_W-1:0] next_rdata;

  // Register state
  logic [CTRL_W-1:0] ctrl [NUM_CH];
  logic [CTRL_W-1:0] next_ctrl [NUM_CH];
  logic [NUM_CH-1:0] code_write;
  logic [NUM_CH-1:0] next_code_write;
  logic d_buffer_mode_bit;
  logic next_d_buffer_mode_bit;

  // Capture state
  logic [COUNT_W-1:0] captured [NUM_CH];
  logic [COUNT_W-1:0] next_captured [NUM_CH];
  logic [NUM_CH-1:0] capture_now;
  logic [NUM_CH-1:0] next_capture_strobe;
  tpic_pin_t pins [NUM_CH];

  // Channel index for a control register offset, NUM_CH if none
  function automatic int ctrl_index(input logic [ADDR_W-1:0] a);
    int idx;
    idx = NUM_CH;
    case (a)
      OFF_CTRL_CH0_LOW: idx = 0;
      OFF_CTRL_CH1: idx = 1;
      OFF_CTRL_CH2: idx = 2;
      OFF_CTRL_CH3: idx = 3;
      default: idx = NUM_CH;
    endcase
    return idx;
  endfunction : ctrl_index

  // Channel index for a capture store offset, NUM_CH if none
  function automatic int capt_index(input logic [ADDR_W-1:0] a);
    int idx;
    idx = NUM_CH;
    case (a)
      OFF_CAPT_CH0_D: idx = 0;
      OFF_CAPT_CH1: idx = 1;
      OFF_CAPT_CH2: idx = 2;
      OFF_CAPT_CH3: idx = 3;
      default: idx = NUM_CH;
    endcase
    return idx;
  endfunction : capt_index

  // Write channels, register updates and response
  always_comb begin
    int wi;
    wi = NUM_CH;
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_lane0 = w_lane0;
    next_bvalid = s_bvalid;
    next_bresp = s_bresp;
    next_code_write = '0;
    next_d_buffer_mode_bit = d_buffer_mode_bit;
    // Registers keep their values unless written
    for (int i = 0; i < NUM_CH; i++) begin
      next_ctrl[i] = ctrl[i];
    end
    // Take address and data as each handshake completes
    if (s_awvalid && s_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_wdata;
      next_w_lane0 = s_wstrb[0];
    end
    // Response leaves once it is taken
    if (s_bvalid && s_bready) begin
      next_bvalid = 1'b0;
    end
    // Commit once both halves are held and no response is pending
    if (aw_held && w_held && !s_bvalid) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = RESP_OKAY;
      wi = ctrl_index(aw_addr);
      if (wi < NUM_CH) begin
        if (w_lane0) begin
          next_ctrl[wi] = w_data[CTRL_W-1:0];
          next_code_write[wi] = 1'b1; // RL10
        end
      end else if (aw_addr == OFF_MODE_CH0) begin
        if (w_lane0) begin
          next_d_buffer_mode_bit = w_data[BUF_MODE_BIT];
        end
      end else if (capt_index(aw_addr) == NUM_CH) begin
        next_bresp = RESP_SLVERR;
      end
    end
    // Each ready drops while its own half is held or a response is pending
    next_awready = ~next_aw_held & ~next_bvalid;
    next_wready = ~next_w_held & ~next_bvalid;
  end

  // Read channel
  always_comb begin
    int ri;
    ri = NUM_CH;
    next_rvalid = s_rvalid;
    next_rdata = s_rdata;
    next_rresp = s_rresp;
    if (s_rvalid && s_rready) begin
      next_rvalid = 1'b0;
    end
    // Answer an accepted address in the next cycle
    if (s_arvalid && s_arready) begin
      next_rvalid = 1'b1;
      next_rdata = '0;
      next_rresp = RESP_OKAY;
      if (ctrl_index(s_araddr) < NUM_CH) begin
        ri = ctrl_index(s_araddr);
        next_rdata[CTRL_W-1:0] = ctrl[ri];
      end else if (capt_index(s_araddr) < NUM_CH) begin
        ri = capt_index(s_araddr);
        next_rdata[COUNT_W-1:0] = captured[ri];
      end else if (s_araddr == OFF_MODE_CH0) begin
        next_rdata[BUF_MODE_BIT] = d_buffer_mode_bit;
      end else begin
        next_rresp = RESP_SLVERR;
      end
    end
    // One read at a time
    next_arready = ~next_rvalid;
  end

  // Capture store latches the count on a capture request
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      next_captured[i] = capture_now[i] ? count : captured[i]; // RL5
    end
    next_capture_strobe = capture_now;
  end

  // Write channel and register flops
  always_ff @(posedge clock) begin
    if (rst) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held <= 1'b0;
      w_data <= '0;
      w_lane0 <= 1'b0;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OKAY;
      code_write <= '0;
      d_buffer_mode_bit <= 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
        ctrl[i] <= CTRL_RESET;
      end
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_lane0 <= next_w_lane0;
      s_awready <= next_awready;
      s_wready <= next_wready;
      s_bvalid <= next_bvalid;
      s_bresp <= next_bresp;
      code_write <= next_code_write;
      d_buffer_mode_bit <= next_d_buffer_mode_bit;
      for (int i = 0; i < NUM_CH; i++) begin
        ctrl[i] <= next_ctrl[i];
      end
    end
  end

  // Read channel flops
  always_ff @(posedge clock) begin
    if (rst) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= '0;
      s_rresp <= RESP_OKAY;
    end else begin
      s_arready <= next_arready;
      s_rvalid <= next_rvalid;
      s_rdata <= next_rdata;
      s_rresp <= next_rresp;
    end
  end

  // Capture store flops
  always_ff @(posedge clock) begin
    if (rst) begin
      capture_strobe <= '0;
      for (int i = 0; i < NUM_CH; i++) begin
        captured[i] <= '0;
      end
    end else begin
      capture_strobe <= next_capture_strobe;
      for (int i = 0; i < NUM_CH; i++) begin
        captured[i] <= next_captured[i];
      end
    end
  end

  // Pin channels; only channel 1 may take the channel-0 C event
  for (genvar g = 0; g < NUM_CH; g++) begin : gen_ch
    tpic_edge_t edges;
    tpic_pin_sync u_sync (
      .clock(clock),
      .rst(rst),
      .pin_async(pin_in[g]),
      .edges(edges)
    );
    tpic_channel #(
      .CROSS_OK(g == 1) // RL8
    ) u_chan (
      .clock(clock),
      .rst(rst),
      .code(ctrl[g][CODE_LSB +: CODE_W]),
      .code_write(code_write[g]),
      .disable_io((g == 0) && d_buffer_mode_bit), // RL9
      .standby(standby),
      .compare_match(compare_match[g]),
      .cross_event(ch0_c_event),
      .edges(edges),
      .pin(pins[g]),
      .capture_now(capture_now[g])
    );
    // Pin drive comes straight from the channel flops
    assign pin_out[g] = pins[g].out;
    assign pin_oe[g] = pins[g].oe;
  end

endmodule : tpic_top

// *** testbench/tpic_pins_model.sv ***
// Pin-side model: external drivers on the four timer pins.
// Assumes the bench sets ext_level; a pin driven by the block wins.
`timescale 1ns/1ps
module tpic_pins_model (
  // From the block
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  // From the bench
  input wire logic [3:0] ext_level,
  // To the block
  output logic [3:0] pin_in
);
  // Wire level from both parties, chosen by the block's enable
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : tpic_pins_model

// *** testbench/tpic_top_chk.sv ***
// Checker for the pin I/O control top level.
// Assumes it is bound into tpic_top and sees only its ports.
`timescale 1ns/1ps
module tpic_top_chk
  import tpic_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Register bus
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic s_bvalid,
  input wire logic s_bready,
  input wire logic [1:0] s_bresp,
  input wire logic s_arvalid,
  input wire logic s_arready,
  input wire logic s_rvalid,
  input wire logic s_rready,
  input wire logic [DATA_W-1:0] s_rdata,
  // Timer side
  input wire logic [NUM_CH-1:0] compare_match,
  input wire logic standby,
  input wire logic [NUM_CH-1:0] pin_out,
  input wire logic [NUM_CH-1:0] pin_oe,
  input wire logic [NUM_CH-1:0] capture_strobe
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // Pins and bus handshakes
  chk_reset_pins_low: assert property ($fell(rst) |-> pin_out == 4'h0 && pin_oe == 4'hf)
    else $error("pins not driven low after reset");
  chk_standby_pins_low: assert property (standby |=> pin_out == 4'h0 && pin_oe == 4'hf)
    else $error("pins not driven low in standby");
  chk_pin_change_cause: assert property (
    (((pin_out ^ $past(pin_out)) & ~$past(compare_match) & pin_oe) != 4'h0)
    |-> $past(rst) || $past(standby) || $past(s_bvalid) || $past(s_bvalid, 2))
    else $error("pin changed without match or write");
  chk_oe_change_cause: assert property ($changed(pin_oe)
    |-> $past(rst) || $past(standby) || $past(s_bvalid) || $past(s_bvalid, 2))
    else $error("pin enable changed without write");
  chk_write_latency: assert property (s_awvalid && s_awready && s_wvalid && s_wready |-> ##2 s_bvalid)
    else $error("write response late");
  chk_read_latency: assert property (s_arvalid && s_arready |=> s_rvalid)
    else $error("read data late");
  chk_b_stands: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write response dropped");
  chk_r_stands: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data dropped");
  chk_busy_blocks: assert property (s_bvalid |-> !s_awready && !s_wready)
    else $error("write taken while response pending");

  // Main scenarios
  cov_match_pin: cover property (compare_match[1] ##1 $changed(pin_out[1]));
  cov_capture: cover property (capture_strobe[2]);
  cov_cross: cover property (capture_strobe[1]);
  cov_standby: cover property ($fell(standby));
endmodule : tpic_top_chk

bind tpic_top tpic_top_chk u_chk (.clock(clock), .rst(rst), .s_awvalid(s_awvalid), .s_awready(s_awready),
  .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_bresp(s_bresp),
  .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rvalid(s_rvalid), .s_rready(s_rready), .s_rdata(s_rdata),
  .compare_match(compare_match), .standby(standby), .pin_out(pin_out), .pin_oe(pin_oe),
  .capture_strobe(capture_strobe));

// *** testbench/timer_pin_io_control_test.sv ***
// Self-checking bench for the timer pin I/O control block.
// Assumes the pin model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module timer_pin_io_control_test;
  import tpic_pkg::*;
  logic clock = 0, rst = 1, s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
  logic ch0_c_event = 0, standby = 0, s_awready, s_wready, s_bvalid, s_arready, s_rvalid, p, seen;
  logic [ADDR_W-1:0] s_awaddr = 0, s_araddr = 0;
  logic [DATA_W-1:0] s_wdata = 0, s_rdata, d;
  logic [15:0] count = 0;
  logic [3:0] compare_match = 0, ext_level = 0, pin_in, pin_out, pin_oe, capture_strobe, c;
  logic [1:0] s_bresp, s_rresp, r;
  int n_fail = 0, n_compared = 0;
  // Clock
  always #50 clock = ~clock;
  tpic_top DUT (.clock(clock), .rst(rst), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_awaddr(s_awaddr),
    .s_awprot(3'h0), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_wdata(s_wdata), .s_wstrb(4'hf),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_bresp(s_bresp), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_araddr(s_araddr), .s_arprot(3'h0), .s_rvalid(s_rvalid), .s_rready(s_rready), .s_rdata(s_rdata),
    .s_rresp(s_rresp), .count(count), .compare_match(compare_match), .ch0_c_event(ch0_c_event),
    .standby(standby), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .capture_strobe(capture_strobe));
  tpic_pins_model pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .pin_in(pin_in));

  // Compare and count
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %0t saw %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick
  // Bus write; only the watchdog ends the wait for the response
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_awaddr <= a;
    s_wdata <= v;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (s_bvalid !== 1'b1);
    s_bready <= 1'b1;
    @(posedge clock);
    r = s_bresp;
    s_bready <= 1'b0;
  endtask : wr
  // Bus read
  task automatic rd(input logic [7:0] a);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    do begin
      @(posedge clock);
    end while (s_arready !== 1'b1);
    s_arvalid <= 1'b0;
    do begin
      @(posedge clock);
    end while (s_rvalid !== 1'b1);
    s_rready <= 1'b1;
    @(posedge clock);
    d = s_rdata;
    r = s_rresp;
    s_rready <= 1'b0;
  endtask : rd
  // One compare match pulse on channel ch
  task automatic pulse(input int ch);
    compare_match[ch] <= 1'b1;
    tick(1);
    compare_match[ch] <= 1'b0;
    tick(1);
  endtask : pulse

  // Reset levels, readback, unmapped place
  task automatic t_reset;
    chk(pin_out, 4'h0);
    chk(pin_oe, 4'hf);
    pulse(1);
    chk(pin_out[1], 1'b0);
    rd(OFF_CTRL_CH1);
    chk(d, CTRL_RESET);
    rd(8'h40);
    chk(d, 32'h0);
    chk(r, RESP_SLVERR);
    wr(8'h40, 32'h0);
    chk(r, RESP_SLVERR);
    wr(OFF_CAPT_CH1, 32'hffff);
    chk(r, RESP_OKAY);
    rd(OFF_CAPT_CH1);
    chk(d, 32'h0);
    $display("reset test done");
  endtask : t_reset
  // Every output compare code on channels 1 to 3
  task automatic t_outputs;
    logic [3:0] codes [8] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h0, 4'h4};
    for (int ch = 1; ch < 4; ch++) begin
      foreach (codes[i]) begin
        c = codes[i];
        p = (c[1:0] == 2'h0) ? p : c[2];
        wr(8'(4 * (ch - 1)), {24'h0, c, 4'h0});
        tick(2);
        chk({pin_oe[ch], pin_out[ch]}, {1'b1, p});
        for (int j = 0; j < 2; j++) begin
          pulse(ch);
          p = (c[1:0] == 2'h1) ? 1'b0 : (c[1:0] == 2'h2) ? 1'b1 : (c[1:0] == 2'h3) ? ~p : p;
          chk(pin_out[ch], p);
        end
        rd(8'(4 * (ch - 1)));
        chk(d, {24'h0, c, 4'h0});
      end
    end
    $display("output test done");
  endtask : t_outputs
  // Drive one pin edge and look for a capture
  task automatic pedge(input int ch, input logic lvl, input logic e, input logic [15:0] v);
    count <= v;
    ext_level[ch] <= lvl;
    seen = 1'b0;
    repeat (12) begin
      @(posedge clock);
      seen |= capture_strobe[ch];
    end
    chk(seen, e);
    rd((ch == 0) ? OFF_CAPT_CH0_D : 8'(OFF_CAPT_CH1 + 4 * (ch - 1)));
    if (e) chk(d, {16'h0, v});
  endtask : pedge
  // Capture codes on channels 2 and 3, bit 6 ignored there
  task automatic t_capture;
    logic [3:0] codes [5] = '{4'h8, 4'h9, 4'ha, 4'hb, 4'hc};
    for (int ch = 2; ch < 4; ch++) begin
      foreach (codes[i]) begin
        c = codes[i];
        ext_level[ch] <= 1'b0;
        wr(8'(4 * (ch - 1)), {24'h0, c, 4'h0});
        tick(6);
        pedge(ch, 1'b1, c[1] | ~c[0], {8'(ch), 4'h1, c});
        pedge(ch, 1'b0, c[1] | c[0], {8'(ch), 4'h2, c});
      end
    end
    $display("capture test done");
  endtask : t_capture
  // Channel 1 capture on the channel-0 C event
  task automatic t_cross;
    wr(OFF_CTRL_CH1, 32'hc0);
    count <= 16'h5a5a;
    ch0_c_event <= 1'b1;
    tick(1);
    ch0_c_event <= 1'b0;
    seen = 1'b0;
    repeat (4) begin
      @(posedge clock);
      seen |= capture_strobe[1];
    end
    chk(seen, 1'b1);
    rd(OFF_CAPT_CH1);
    chk(d, 32'h5a5a);
    $display("cross test done");
  endtask : t_cross
  // Buffer mode blocks matches on channel 0
  task automatic t_buffer;
    wr(OFF_MODE_CH0, 32'h1);
    wr(OFF_CTRL_CH0_LOW, 32'h30);
    pulse(0);
    chk(pin_out[0], 1'b0);
    wr(OFF_MODE_CH0, 32'h0);
    pulse(0);
    chk(pin_out[0], 1'b1);
    wr(OFF_MODE_CH0, 32'h1);
    wr(OFF_CTRL_CH0_LOW, 32'ha0);
    pedge(0, 1'b1, 1'b0, 16'h0d0d);
    wr(OFF_MODE_CH0, 32'h0);
    pedge(0, 1'b0, 1'b1, 16'h0e0e);
    $display("buffer test done");
  endtask : t_buffer
  // Standby forces low and clears the written state
  task automatic t_standby;
    wr(OFF_CTRL_CH1, 32'h70);
    standby <= 1'b1;
    tick(2);
    chk({pin_oe[1], pin_out[1]}, 2'h2);
    standby <= 1'b0;
    pulse(1);
    chk(pin_out[1], 1'b0);
    $display("standby test done");
  endtask : t_standby

  // Verdict and end of run
  task automatic finish_test;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  // Watchdog
  initial begin
    tick(30000);
    n_fail++;
    finish_test();
  end
  // Main sequence
  initial begin
    tick(6);
    rst <= 1'b0;
    tick(2);
    t_reset();
    t_outputs();
    t_capture();
    t_cross();
    t_buffer();
    t_standby();
    finish_test();
  end
endmodule : timer_pin_io_control_test
